// *** cscon_top.sv ***
// Charger state controller: charge phases, status pins and switcher cycle supervision.
`timescale 1ns/100ps
`default_nettype none
module cscon_top #(
  parameter longint unsigned BAD_BAT_LIMIT = cscon_pkg::BAD_BAT_CYC,
  parameter longint unsigned SAFETY_LIMIT  = cscon_pkg::SAFETY_CYC,
  parameter int unsigned     C10_LIMIT     = cscon_pkg::C10_FILTER_CYC,
  parameter int unsigned     RECHG_LIMIT   = cscon_pkg::RECHG_FILTER_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic run_en_in,
  input  wire logic run_hold_in,
  input  wire logic run_sd_n_in,
  input  wire logic diff_uvlo_in,
  input  wire logic deep_discharge_in,
  input  wire logic trickle_in,
  input  wire logic float_in,
  input  wire logic recharge_in,
  input  wire logic ntc_fault_in,
  input  wire logic bat_present_in,
  input  wire logic current_monitor_low_in,
  input  wire logic cur_low_in,
  input  wire logic cur_high_in,
  input  wire logic select_a_in,
  input  wire logic top_req_in,
  input  wire logic il_zero_in,
  output logic      charge_indicator_oe_out,
  output logic      charge_indicator_o_out,
  output logic      fault_indicator_oe_out,
  output logic      fault_indicator_o_out,
  output logic      divider_ground_return_oe_out,
  output logic      divider_ground_return_o_out,
  output logic      shutdown_out,
  output logic      switch_en_out,
  output logic      precond_en_out,
  output logic      trickle_level_out,
  output logic      skip_mode_out,
  output logic      standby_out,
  output logic      top_on_out,
  output logic      bottom_on_out,
  output logic      cycle_start_out,
  output cscon_pkg::cscon_state_e state_out
);
  import cscon_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned NIN = 15;
  // Reset loads idle levels, so no false shutdown follows the release of reset.
  localparam logic [NIN-1:0] SYNC_IDLE = 15'h1000;
  logic [NIN-1:0] raw_w;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  assign raw_w = {run_en_in, run_hold_in, run_sd_n_in, diff_uvlo_in, deep_discharge_in,
                  trickle_in, float_in, recharge_in, ntc_fault_in, bat_present_in,
                  current_monitor_low_in, cur_low_in, cur_high_in, select_a_in, il_zero_in};

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end
    else
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end

  logic run_en, run_hold, run_sd_n, uvlo, deep, trk, flt, rchg, ntc, bat, mon_low;
  logic cur_low, cur_high, fsel, il_zero;
  assign {run_en, run_hold, run_sd_n, uvlo, deep, trk, flt, rchg, ntc, bat, mon_low,
          cur_low, cur_high, fsel, il_zero} = s2_q;

  // ****************************************
  // Filters
  // ****************************************
  logic c10_w;
  logic rchg_w;
  cscon_filter #(.CYCLES(C10_LIMIT)) u_c10 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .level_in (mon_low),
    .held_out (c10_w)
  );
  cscon_filter #(.CYCLES(RECHG_LIMIT)) u_rchg (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .level_in (rchg),
    .held_out (rchg_w)
  );

  // ****************************************
  // Charge state machine
  // ****************************************
  cscon_state_e    state_q;
  logic [TIMER_W-1:0] timer_q;
  logic            timer_done_w;
  logic            active_w;
  assign active_w = (state_q == CSCON_PRECOND) || (state_q == CSCON_TRICKLE) ||
                    (state_q == CSCON_FULL);
  assign timer_done_w = (state_q == CSCON_TRICKLE) ? (timer_q >= TIMER_W'(BAD_BAT_LIMIT))
                                                   : (timer_q >= TIMER_W'(SAFETY_LIMIT));

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= CSCON_DISABLED;
    end
    else if (!run_sd_n || uvlo)
    begin
      state_q <= CSCON_SHUTDOWN;
    end
    else if (!run_hold || (state_q == CSCON_SHUTDOWN))
    begin
      state_q <= CSCON_DISABLED;
    end
    else
    begin
      case (state_q)
        CSCON_DISABLED:
          if (run_en && bat) state_q <= CSCON_PRECOND;
        CSCON_PRECOND:
          if (!deep) state_q <= CSCON_TRICKLE;
        CSCON_TRICKLE:
          if (deep) state_q <= CSCON_PRECOND;
          else if (trk) state_q <= CSCON_FULL;
          else if (timer_done_w) state_q <= CSCON_BAD_BAT;
        CSCON_FULL:
          if (flt && timer_done_w) state_q <= CSCON_SLEEP;
        CSCON_SLEEP:
          if (rchg_w) state_q <= CSCON_PRECOND;
        CSCON_BAD_BAT:
          if (!bat) state_q <= CSCON_DISABLED;
        default:
          state_q <= CSCON_DISABLED;
      endcase
    end
  end

  // The timer counts trickle time, and safety time only once float is reached.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !active_w)
    begin
      timer_q <= '0;
    end
    else if (state_q == CSCON_TRICKLE && !trk && !ntc)
    begin
      timer_q <= timer_q + 1'b1;
    end
    else if (state_q == CSCON_FULL && flt && !ntc)
    begin
      timer_q <= timer_q + 1'b1;
    end
    else if (state_q == CSCON_TRICKLE && trk)
    begin
      timer_q <= '0;
    end
  end

  // ****************************************
  // Status pins
  // ****************************************
  logic chg_low_d;
  logic flt_low_d;
  always_comb
  begin
    chg_low_d = active_w && (ntc || !c10_w);
    flt_low_d = (state_q == CSCON_BAD_BAT) || (active_w && ntc);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      charge_indicator_oe_out <= 1'b0;
      fault_indicator_oe_out  <= 1'b0;
    end
    else
    begin
      charge_indicator_oe_out <= chg_low_d;
      fault_indicator_oe_out  <= flt_low_d;
    end
  end
  assign charge_indicator_o_out       = 1'b0;
  assign fault_indicator_o_out        = 1'b0;
  assign divider_ground_return_o_out  = 1'b0;
  assign divider_ground_return_oe_out = active_w || (state_q == CSCON_SLEEP) ||
                                        (state_q == CSCON_BAD_BAT);
  assign shutdown_out      = (state_q == CSCON_SHUTDOWN);
  assign state_out         = state_q;
  assign switch_en_out     = ((state_q == CSCON_TRICKLE) || (state_q == CSCON_FULL)) && !ntc;
  assign precond_en_out    = (state_q == CSCON_PRECOND) || (state_q == CSCON_TRICKLE);
  assign trickle_level_out = (state_q == CSCON_TRICKLE);

  // ****************************************
  // Switching cycle, dropout and refresh
  // ****************************************
  logic [8:0] div_q;
  logic       tick_w;
  assign tick_w = (div_q == 9'h000);
  assign cycle_start_out = tick_w && switch_en_out;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || tick_w)
    begin
      div_q <= (fsel ? FAST_DIV : SLOW_DIV) - 9'h001;
    end
    else
    begin
      div_q <= div_q - 9'h001;
    end
  end

  // Pulse skipping is entered only outside constant current, with hysteresis.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !switch_en_out)
    begin
      skip_mode_out <= 1'b0;
    end
    else if (!skip_mode_out && flt && cur_low)
    begin
      skip_mode_out <= 1'b1;
    end
    else if (skip_mode_out && cur_high)
    begin
      skip_mode_out <= 1'b0;
    end
  end

  logic [2:0] burst_q;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !skip_mode_out)
    begin
      burst_q <= '0;
    end
    else if (tick_w)
    begin
      burst_q <= burst_q + 3'h1;
    end
  end
  assign standby_out = skip_mode_out && (burst_q >= STANDBY_CYCLES);

  logic [3:0] drop_q;
  logic [5:0] refr_q;
  logic       force_bot_q;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !switch_en_out)
    begin
      drop_q      <= '0;
      refr_q      <= '0;
      force_bot_q <= 1'b0;
      top_on_out  <= 1'b0;
    end
    else if (tick_w)
    begin
      if (refr_q >= REFRESH_CYCLES)
      begin
        force_bot_q <= 1'b1;
        top_on_out  <= 1'b0;
        refr_q      <= '0;
      end
      else
      begin
        force_bot_q <= 1'b0;
        top_on_out  <= top_req_in && !standby_out;
        refr_q      <= refr_q + 6'h01;
        drop_q      <= (top_req_in && top_on_out) ? drop_q + 4'h1 : 4'h0;
      end
    end
    else
    begin
      if (top_on_out && (drop_q >= DROPOUT_CYCLES - 4'h1))
      begin
        top_on_out  <= 1'b0;
        force_bot_q <= 1'b1;
        drop_q      <= '0;
      end
      else if (force_bot_q && il_zero)
      begin
        force_bot_q <= 1'b0;
      end
      if (bottom_on_out)
      begin
        refr_q <= '0;
      end
    end
  end
  assign bottom_on_out = force_bot_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_rst_idle;
    @(posedge clk_in) !rst_n_in |=> (state_q == CSCON_DISABLED) && !charge_indicator_oe_out;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset not idle");

  property p_bad_fault;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == CSCON_BAD_BAT) |=> fault_indicator_oe_out || state_q != CSCON_BAD_BAT;
  endproperty
  a_bad_fault: assert property (p_bad_fault) else $error("bad battery not flagged");

  property p_bad_chg;
    @(posedge clk_in) disable iff (!rst_n_in)
      $past(state_q == CSCON_BAD_BAT) && state_q == CSCON_BAD_BAT |-> !charge_indicator_oe_out;
  endproperty
  a_bad_chg: assert property (p_bad_chg) else $error("charge low on bad battery");

  property p_disabled_rel;
    @(posedge clk_in) disable iff (!rst_n_in)
      $past(state_q == CSCON_DISABLED) |-> !charge_indicator_oe_out && !fault_indicator_oe_out;
  endproperty
  a_disabled_rel: assert property (p_disabled_rel) else $error("pins low when off");

  property p_fbg_float;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == CSCON_DISABLED) |-> !divider_ground_return_oe_out;
  endproperty
  a_fbg_float: assert property (p_fbg_float) else $error("divider return driven");

  property p_uvlo;
    @(posedge clk_in) disable iff (!rst_n_in) (s2_q[11] && run_sd_n) |=> shutdown_out;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("no shutdown on uvlo");

  property p_precond;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == CSCON_PRECOND) |-> !switch_en_out && precond_en_out;
  endproperty
  a_precond: assert property (p_precond) else $error("switching in precondition");

  property p_full;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == CSCON_FULL) |-> !precond_en_out && !trickle_level_out;
  endproperty
  a_full: assert property (p_full) else $error("precondition in full");

  property p_dropout;
    @(posedge clk_in) disable iff (!rst_n_in)
      switch_en_out && !tick_w && top_on_out && (drop_q >= DROPOUT_CYCLES - 4'h1)
      |=> bottom_on_out && !top_on_out;
  endproperty
  a_dropout: assert property (p_dropout) else $error("dropout did not force bottom");

  property p_refresh;
    @(posedge clk_in) disable iff (!rst_n_in) refr_q <= REFRESH_CYCLES;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh count overran");

  c_charge: cover property (@(posedge clk_in) state_q == CSCON_FULL);
  c_bad:    cover property (@(posedge clk_in) state_q == CSCON_BAD_BAT);
  c_skip:   cover property (@(posedge clk_in) standby_out);
  c_drop:   cover property (@(posedge clk_in) bottom_on_out);

endmodule
`default_nettype wire

// *** cscon_pkg.sv ***
// Package of constants, types and timing figures for the charger state controller.
package cscon_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 200;
  localparam longint unsigned BAD_BAT_MIN  = 30;
  localparam longint unsigned SAFETY_MIN   = 120;
  localparam int unsigned C10_FILTER_US    = 350;
  localparam int unsigned RECHG_FILTER_US  = 500;
  localparam longint unsigned BAD_BAT_CYC  = BAD_BAT_MIN * 64'd60 * 64'd1000000 * CLK_MHZ;
  localparam longint unsigned SAFETY_CYC   = SAFETY_MIN * 64'd60 * 64'd1000000 * CLK_MHZ;
  localparam int unsigned C10_FILTER_CYC   = C10_FILTER_US * CLK_MHZ;
  localparam int unsigned RECHG_FILTER_CYC = RECHG_FILTER_US * CLK_MHZ;
  // Switching periods in system clocks: 1.5 MHz and 750 kHz, rounded down.
  localparam int unsigned FAST_KHZ         = 1500;
  localparam int unsigned SLOW_KHZ         = 750;
  localparam logic [8:0]  FAST_DIV         = 9'(CLK_MHZ * 1000 / FAST_KHZ);
  localparam logic [8:0]  SLOW_DIV         = 9'(CLK_MHZ * 1000 / SLOW_KHZ);
  localparam logic [3:0]  DROPOUT_CYCLES   = 4'h8;
  localparam logic [5:0]  REFRESH_CYCLES   = 6'h20;
  localparam logic [2:0]  STANDBY_CYCLES   = 3'h4;
  localparam int unsigned TIMER_W          = 44;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CSCON_SHUTDOWN,
    CSCON_DISABLED,
    CSCON_PRECOND,
    CSCON_TRICKLE,
    CSCON_FULL,
    CSCON_SLEEP,
    CSCON_BAD_BAT
  } cscon_state_e;

endpackage

// *** cscon_filter.sv ***
// Persistence filter: output rises only after the level holds high for a set count, and falls at once.
`timescale 1ns/100ps
`default_nettype none
module cscon_filter #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output logic      held_out
);
  import cscon_pkg::*;

  logic [$clog2(CYCLES+1)-1:0] cnt_q;

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !level_in)
    begin
      cnt_q    <= '0;
      held_out <= 1'b0;
    end
    else if (cnt_q < ($clog2(CYCLES+1))'(CYCLES))
    begin
      cnt_q    <= cnt_q + 1'b1;
      held_out <= 1'b0;
    end
    else
    begin
      held_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** cscon_batt_model.sv ***
// Battery pack, thermistor and pulled-up status lines seen from the charger controller.
`timescale 1ns/100ps
`default_nettype none
module cscon_batt_model #(
  parameter int unsigned DEEP_MV  = 2050,
  parameter int unsigned TRICKLE_MV  = 2900,
  parameter int unsigned FLOAT_MV = 4200,
  parameter int unsigned RECHG_MV = 4108
) (
  input  wire logic [15:0] bat_mv_in,
  input  wire logic        present_in,
  input  wire logic        hot_in,
  input  wire logic        chg_oe_in,
  input  wire logic        chg_o_in,
  input  wire logic        flt_oe_in,
  input  wire logic        flt_o_in,
  output logic             deep_out,
  output logic             trickle_out,
  output logic             float_out,
  output logic             recharge_out,
  output logic             present_out,
  output logic             ntc_out,
  output logic             chg_line_out,
  output logic             flt_line_out
);
  logic [15:0] mv;
  // An absent pack reads as a flat cell, so no comparator keeps a stale level.
  assign mv           = present_in ? bat_mv_in : 16'h0000;
  assign deep_out     = (32'(mv) < DEEP_MV);
  assign trickle_out  = (32'(mv) > TRICKLE_MV);
  assign float_out    = (32'(mv) >= FLOAT_MV);
  assign recharge_out = (32'(mv) < RECHG_MV);
  assign present_out  = present_in;
  assign ntc_out      = hot_in;
  // Both lines carry pull-ups, so a released line reads high.
  assign chg_line_out = chg_oe_in ? chg_o_in : 1'b1;
  assign flt_line_out = flt_oe_in ? flt_o_in : 1'b1;
endmodule
`default_nettype wire

// *** cscon_top_tb.sv ***
// Self-checking testbench of the charger state controller.
`timescale 1ns/100ps
`default_nettype none
module cscon_top_tb;
  import cscon_pkg::*;
  localparam longint unsigned BAD = 400;
  localparam longint unsigned SAFE = 6000;
  localparam int unsigned C10 = 40;
  localparam int unsigned RCH = 40;
  localparam int CEILING = 40000;
  logic clk = 1'b0, rst_n = 1'b0, run_en = 1'b0, run_hold = 1'b1, run_sd_n = 1'b1;
  logic uvlo = 1'b0, present = 1'b1, hot = 1'b0, cm_low = 1'b0, cur_low = 1'b0;
  logic cur_high = 1'b0, sel = 1'b1, top_req = 1'b0, il_zero = 1'b0;
  logic [15:0] bat_mv = 16'd1500;
  logic deep, trickle, flt, rchg, pres, ntc, chg_line, flt_line;
  logic chg_oe, chg_o, flt_oe, flt_o, dgr_oe, sd, sw_en, pre_en, trickle_lvl;
  logic skip, stby, top_on, bot_on, cyc_start;
  cscon_state_e state;
  int fails = 0, samples_checked = 0, cyc = 0, n, k;
  logic [7:0] rnd = 8'h1C;
  logic seen_stby;
  always #2.5 clk = ~clk;
  cscon_top #(.BAD_BAT_LIMIT(BAD), .SAFETY_LIMIT(SAFE), .C10_LIMIT(C10), .RECHG_LIMIT(RCH)) i_dut (
    .clk_in(clk), .rst_n_in(rst_n), .run_en_in(run_en), .run_hold_in(run_hold),
    .run_sd_n_in(run_sd_n), .diff_uvlo_in(uvlo), .deep_discharge_in(deep),
    .trickle_in(trickle), .float_in(flt), .recharge_in(rchg), .ntc_fault_in(ntc),
    .bat_present_in(pres), .current_monitor_low_in(cm_low), .cur_low_in(cur_low),
    .cur_high_in(cur_high), .select_a_in(sel), .top_req_in(top_req), .il_zero_in(il_zero),
    .charge_indicator_oe_out(chg_oe), .charge_indicator_o_out(chg_o),
    .fault_indicator_oe_out(flt_oe), .fault_indicator_o_out(flt_o),
    .divider_ground_return_oe_out(dgr_oe), .divider_ground_return_o_out(),
    .shutdown_out(sd), .switch_en_out(sw_en), .precond_en_out(pre_en),
    .trickle_level_out(trickle_lvl), .skip_mode_out(skip), .standby_out(stby),
    .top_on_out(top_on), .bottom_on_out(bot_on), .cycle_start_out(cyc_start),
    .state_out(state));
  cscon_batt_model i_batt (
    .bat_mv_in(bat_mv), .present_in(present), .hot_in(hot), .chg_oe_in(chg_oe),
    .chg_o_in(chg_o), .flt_oe_in(flt_oe), .flt_o_in(flt_o), .deep_out(deep),
    .trickle_out(trickle), .float_out(flt), .recharge_out(rchg), .present_out(pres),
    .ntc_out(ntc), .chg_line_out(chg_line), .flt_line_out(flt_line));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Expected {fault line, charge line}; thermal pause wins over the current monitor.
  function automatic logic [1:0] exp_lines(input cscon_state_e st, input logic t, input logic c);
    if (st == CSCON_BAD_BAT)
      return 2'b01;
    if (st == CSCON_PRECOND || st == CSCON_TRICKLE || st == CSCON_FULL)
      return t ? 2'b00 : {1'b1, c};
    return 2'b11;
  endfunction
  function automatic int exp_period(input logic s);
    return s ? int'(FAST_DIV) : int'(SLOW_DIV);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_pins(input cscon_state_e st);
    check("state", 16'(state), 16'(st));
    check("lines", {14'h0, flt_line, chg_line}, {14'h0, exp_lines(st, hot, cm_low)});
  endtask
  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, fails);
  endtask
  // Counts clocks from one switching-period pulse to the next.
  task automatic measure(output int p);
    k = 0;
    while (cyc_start !== 1'b1 && k < 1000)
    begin
      tick(1);
      k++;
    end
    tick(1);
    p = 1;
    while (cyc_start !== 1'b1 && p < 1000)
    begin
      tick(1);
      p++;
    end
  endtask
  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == CEILING)
    begin
      fails++;
      final_report();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    tick(2);
    rst_n = 1'b1;
    tick(5);
    chk_pins(CSCON_DISABLED);
    check("dgr_oe", {15'h0, dgr_oe}, 16'h0);
    run_en = 1'b1;
    tick(5);
    chk_pins(CSCON_PRECOND);
    check("sw_pre", {14'h0, sw_en, pre_en}, 16'h1);
    check("dgr_oe", {15'h0, dgr_oe}, 16'h1);
    bat_mv = 16'd2500;
    tick(5);
    chk_pins(CSCON_TRICKLE);
    check("sw_pre_trk", {13'h0, sw_en, pre_en, trickle_lvl}, 16'h7);
    done("phases");
    tick(int'(BAD / 2));
    chk_pins(CSCON_TRICKLE);
    tick(int'(BAD));
    chk_pins(CSCON_BAD_BAT);
    present = 1'b0;
    tick(5);
    chk_pins(CSCON_DISABLED);
    bat_mv = 16'd3500;
    present = 1'b1;
    tick(10);
    chk_pins(CSCON_FULL);
    check("sw_pre_trk", {13'h0, sw_en, pre_en, trickle_lvl}, 16'h4);
    done("bad battery");
    rnd = lfsr_next(rnd);
    sel = rnd[0];
    repeat (2)
    begin
      tick(5);
      measure(n);
      measure(n);
      check("period", 16'(n), 16'(exp_period(sel)));
      sel = ~sel;
    end
    done("frequency");
    hot = 1'b1;
    tick(5);
    chk_pins(CSCON_FULL);
    hot = 1'b0;
    tick(5);
    cm_low = 1'b1;
    tick(C10 / 2);
    check("chg_line", {15'h0, chg_line}, 16'h0);
    tick(C10 + 5);
    chk_pins(CSCON_FULL);
    check("sw_en", {15'h0, sw_en}, 16'h1);
    cm_low = 1'b0;
    done("indicators");
    // Start just after a refresh, so the refresh counter cannot pre-empt the dropout.
    while (bot_on !== 1'b1)
      tick(1);
    while (bot_on !== 1'b0)
      tick(1);
    top_req = 1'b1;
    n = 0;
    while (bot_on !== 1'b1 && n < 12 * int'(SLOW_DIV))
    begin
      tick(1);
      n++;
    end
    check("dropout", 16'(n >= 7 * exp_period(sel) && n <= 8 * exp_period(sel) + 4), 16'h1);
    check("top_on", {15'h0, top_on}, 16'h0);
    top_req = 1'b0;
    done("dropout");
    bat_mv = 16'd4200;
    cur_low = 1'b1;
    tick(5);
    check("skip", {15'h0, skip}, 16'h1);
    seen_stby = 1'b0;
    repeat (8 * int'(SLOW_DIV))
    begin
      tick(1);
      seen_stby = seen_stby | stby;
    end
    check("standby", {15'h0, seen_stby}, 16'h1);
    cur_low = 1'b0;
    cur_high = 1'b1;
    tick(5);
    check("skip", {15'h0, skip}, 16'h0);
    chk_pins(CSCON_FULL);
    n = 0;
    while (state !== CSCON_SLEEP && n < int'(SAFE) + 100)
    begin
      tick(1);
      n++;
    end
    tick(2);
    chk_pins(CSCON_SLEEP);
    done("top-off and sleep");
    rnd = lfsr_next(rnd);
    bat_mv = 16'd4000;
    tick(int'(rnd) % (RCH / 2) + 1);
    bat_mv = 16'd4200;
    tick(5);
    chk_pins(CSCON_SLEEP);
    bat_mv = 16'd4000;
    tick(RCH + 10);
    chk_pins(CSCON_FULL);
    done("recharge");
    run_hold = 1'b0;
    tick(5);
    chk_pins(CSCON_DISABLED);
    check("dgr_oe", {15'h0, dgr_oe}, 16'h0);
    run_hold = 1'b1;
    run_sd_n = 1'b0;
    tick(5);
    check("shutdown", {14'h0, sd, 16'(state) == 16'(CSCON_SHUTDOWN)}, 16'h3);
    run_sd_n = 1'b1;
    uvlo = 1'b1;
    tick(8);
    check("uvlo", {14'h0, sd, 16'(state) == 16'(CSCON_SHUTDOWN)}, 16'h3);
    uvlo = 1'b0;
    tick(8);
    check("uvlo_exit", {15'h0, sd}, 16'h0);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    chk_pins(CSCON_DISABLED);
    done("run and shutdown");
    final_report();
  end
endmodule
`default_nettype wire
